/* src/sagen_core.sv */
// Segment address generator for code and data segments
//
// Behaviour
// - Code targets are relative to program counter
// - Displacement spans minus 128 to 127
// - Direct target is counter plus signed displacement
// - Indirect adds fetched word to direct target
// - Taken branch fetches at target, then loads counter with target plus one
// - Code constant fetch goes to stack top
// - Register offset added before final code address
// - Code byte access stays in counter's half
// - Data segment holds 65536 sixteen-bit words
// - Stack-top register wraps over the full 16-bit range
// - Data address direct or pointer, plus index
// - Nine memory-reference operations supported
// - Global base equals data address zero
// - Local base register holds procedure area start
// - Local base advances on call, returns on exit
// - Stack-top register holds last defined word
// - Stack top moves on push, pop, call, exit
// - Data accesses issued as word addresses
// - Word load puts data word on stack top
// - Counter holds current instruction plus one
// - Code write attempt raises address trap
`include "sagen_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sagen_core
   import sagen_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // Sequencer requests
   input  wire sagen_req_s       req,
   input  wire logic             req_valid,
   input  wire logic             instr_start,
   input  wire sagen_stk_e       stk_op,
   input  wire logic [15:0]      stk_amount,
   input  wire logic [15:0]      call_local,
   input  wire logic [15:0]      exit_local,
   // Memory side
   input  wire logic [15:0]      mem_rdata,
   input  wire logic             mem_rvalid,
   output var  sagen_mem_s       mem_req,
   // Results
   output logic [15:0]           stack_top_data,
   output logic                  stack_top_load,
   output logic [15:0]           pc,
   output logic [15:0]           local_base,
   output logic [15:0]           stack_ptr,
   output logic                  byte_right,
   output logic                  addr_trap,
   output logic                  busy
);

   typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_OPER, ST_FETCH} sagen_state_e;

   logic [1:0]   rst_sync_q;
   logic         rst_n;
   sagen_state_e state_q;
   sagen_op_e    op_q;
   logic [15:0]  base_q;
   logic [15:0]  index_q;
   logic [15:0]  disp_ext;
   logic [15:0]  dir_target;

   // Wrapping 16-bit add
   function automatic logic [15:0] sag_add(input logic [15:0] a, input logic [15:0] b);
      sag_add = 16'(a + b);
   endfunction : sag_add

   // Clamp a byte-derived code address into the counter's half
   function automatic logic [15:0] sag_half(input logic [15:0] a, input logic [15:0] p);
      sag_half = {p[`SAG_MSB], a[`SAG_HALF_MSB:`SAG_LSB]};
   endfunction : sag_half

   // Sign-extended code displacement
   function automatic logic [15:0] sag_disp(input logic [15:0] i);
      sag_disp = {{`SAG_SIGN_FILL{i[`SAG_DISP_MSB]}}, i[`SAG_DISP_MSB:`SAG_DISP_LSB]};
   endfunction : sag_disp

   // Word part of a byte address or byte index
   function automatic logic [15:0] sag_word_of(input logic [15:0] b);
      sag_word_of = {1'b0, b[`SAG_MSB:`SAG_WORD_LSB]};
   endfunction : sag_word_of

   // Code byte address: word offset added, kept in the counter's half
   function automatic logic [15:0] sag_code_byte(input logic [15:0] a, input logic [15:0] x,
                                                 input logic [15:0] p);
      sag_code_byte = sag_half(sag_add(a, sag_word_of(x)), p);
   endfunction : sag_code_byte

   // Operations that write the data segment
   function automatic logic sag_is_store(input sagen_op_e op);
      sag_is_store = (op == SAG_OP_NSTORE) || (op == SAG_OP_STORE_WORD) ||
                     (op == SAG_OP_STORE_BYTE) || (op == SAG_OP_STORE_DOUBLE);
   endfunction : sag_is_store

   // Byte operations on the data segment
   function automatic logic sag_is_byte(input sagen_op_e op);
      sag_is_byte = (op == SAG_OP_LOAD_BYTE) || (op == SAG_OP_STORE_BYTE);
   endfunction : sag_is_byte

   // Address of the word after a given one
   function automatic logic [15:0] sag_next(input logic [15:0] a);
      sag_next = sag_add(a, `SAG_ONE);
   endfunction : sag_next

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= '0;
      end else begin
         rst_sync_q <= {rst_sync_q[`SAG_LSB], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign disp_ext   = sag_disp(req.instr);
   assign dir_target = sag_add(pc, disp_ext);

   // Request sequencing and memory address generation
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q        <= ST_IDLE;
         op_q           <= SAG_OP_NONE;
         base_q         <= `SAG_ZERO;
         index_q        <= `SAG_ZERO;
         mem_req        <= '0;
         byte_right     <= 1'b0;
         busy           <= 1'b0;
      end else if (clk_en) begin
         case (state_q)
            ST_IDLE: begin
               mem_req <= '0;
               if (req_valid) begin
                  op_q    <= req.op;
                  index_q <= req.index;
                  case (req.op)
                     SAG_OP_NONE: begin
                        busy <= 1'b0;
                     end
                     SAG_OP_CODE_WRITE: begin
                        busy <= 1'b0;
                     end
                     SAG_OP_BRANCH, SAG_OP_CODE_WORD, SAG_OP_CODE_BYTE: begin
                        base_q <= dir_target;
                        busy   <= 1'b1;
                        if (req.instr[`SAG_IND_BIT]) begin
                           mem_req <= '{valid: 1'b1, code_seg: 1'b1, write: 1'b0, addr: dir_target};
                           state_q <= ST_PTR;
                        end else if (req.op == SAG_OP_BRANCH) begin
                           mem_req <= '{valid: 1'b1, code_seg: 1'b1, write: 1'b0, addr: dir_target};
                           state_q <= ST_FETCH;
                        end else if (req.op == SAG_OP_CODE_BYTE) begin
                           mem_req <= '{valid: 1'b1, code_seg: 1'b1, write: 1'b0,
                                        addr: sag_code_byte(dir_target, req.index, pc)};
                           byte_right <= req.index[`SAG_LSB];
                           state_q <= ST_OPER;
                        end else begin
                           mem_req <= '{valid: 1'b1, code_seg: 1'b1, write: 1'b0,
                                        addr: sag_add(dir_target, req.index)};
                           state_q <= ST_OPER;
                        end
                     end
                     default: begin
                        busy   <= 1'b1;
                        base_q <= req.direct_addr;
                        if (req.indirect) begin
                           mem_req <= '{valid: 1'b1, code_seg: 1'b0, write: 1'b0, addr: req.direct_addr};
                           state_q <= ST_PTR;
                        end else begin
                           mem_req <= '{valid: 1'b1, code_seg: 1'b0, write: sag_is_store(req.op),
                                        addr: sag_add(req.direct_addr, req.index)};
                           byte_right <= 1'b0;
                           state_q <= ST_OPER;
                        end
                     end
                  endcase
               end
            end
            ST_PTR: begin
               mem_req.valid <= 1'b0;
               if (mem_rvalid) begin
                  mem_req.valid <= 1'b1;
                  if (mem_req.code_seg) begin
                     if (op_q == SAG_OP_BRANCH) begin
                        mem_req.addr <= sag_add(base_q, mem_rdata);
                        state_q      <= ST_FETCH;
                     end else if (op_q == SAG_OP_CODE_BYTE) begin
                        mem_req.addr <= sag_code_byte(sag_add(base_q, mem_rdata), index_q, pc);
                        byte_right   <= index_q[`SAG_LSB];
                        state_q      <= ST_OPER;
                     end else begin
                        mem_req.addr <= sag_add(sag_add(base_q, mem_rdata), index_q);
                        state_q      <= ST_OPER;
                     end
                  end else begin
                     mem_req.write <= sag_is_store(op_q);
                     if (sag_is_byte(op_q)) begin
                        mem_req.addr <= sag_add(sag_word_of(mem_rdata), index_q);
                        byte_right   <= mem_rdata[`SAG_LSB];
                     end else begin
                        mem_req.addr <= sag_add(mem_rdata, index_q);
                        byte_right   <= 1'b0;
                     end
                     state_q <= ST_OPER;
                  end
               end
            end
            ST_FETCH: begin
               mem_req.valid <= 1'b0;
               if (mem_rvalid) begin
                  state_q <= ST_IDLE;
                  busy    <= 1'b0;
               end
            end
            ST_OPER: begin
               mem_req.valid <= 1'b0;
               if (mem_req.write || mem_rvalid) begin
                  state_q <= ST_IDLE;
                  busy    <= 1'b0;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Operand word handed to the register stack top
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stack_top_data <= `SAG_ZERO;
         stack_top_load <= 1'b0;
      end else if (clk_en) begin
         stack_top_load <= 1'b0;
         if (state_q == ST_OPER && !mem_req.write && mem_rvalid && op_q != SAG_OP_LOAD_INDEX) begin
            stack_top_data <= mem_rdata;
            stack_top_load <= 1'b1;
         end
      end
   end

   // Trap on an attempted code write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_trap <= 1'b0;
      end else if (clk_en) begin
         addr_trap <= state_q == ST_IDLE && req_valid && req.op == SAG_OP_CODE_WRITE;
      end
   end

   // Program counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc <= `SAG_PC_RESET;
      end else if (clk_en) begin
         if (state_q == ST_FETCH && mem_rvalid) begin
            pc <= sag_next(mem_req.addr);
         end else if (instr_start) begin
            pc <= sag_next(pc);
         end
      end
   end

   // Local base register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         local_base <= `SAG_L_RESET;
      end else if (clk_en) begin
         if (stk_op == SAG_STK_CALL) begin
            local_base <= call_local;
         end else if (stk_op == SAG_STK_EXIT) begin
            local_base <= exit_local;
         end
      end
   end

   // Stack-top register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stack_ptr <= `SAG_S_RESET;
      end else if (clk_en) begin
         case (stk_op)
            SAG_STK_PUSH, SAG_STK_CALL: begin
               stack_ptr <= sag_add(stack_ptr, stk_amount);
            end
            SAG_STK_POP, SAG_STK_EXIT: begin
               stack_ptr <= 16'(stack_ptr - stk_amount);
            end
            default: begin
               stack_ptr <= stack_ptr;
            end
         endcase
      end
   end

endmodule : sagen_core

`default_nettype wire

/* src/sagen_defines.svh */
// Constants for the segment address generator
`ifndef SAGEN_DEFINES_SVH
`define SAGEN_DEFINES_SVH
`define SAG_W          16
`define SAG_IND_BIT    15
`define SAG_MSB        15
`define SAG_HALF_MSB   14
`define SAG_LSB        0
`define SAG_WORD_LSB   1
`define SAG_SIGN_FILL  8
`define SAG_DISP_LSB   0
`define SAG_DISP_MSB   7
`define SAG_STACK_TOP  16'h7FFF
`define SAG_ONE        16'h0001
`define SAG_ZERO       16'h0000
`define SAG_PC_RESET   16'h0000
`define SAG_L_RESET    16'h0000
`define SAG_S_RESET    16'h0000
`endif

/* src/sagen_pkg.sv */
// Types for the segment address generator
package sagen_pkg;
   typedef enum logic [3:0] {
      SAG_OP_NONE, SAG_OP_BRANCH, SAG_OP_CODE_WORD, SAG_OP_CODE_BYTE,
      SAG_OP_LOAD_INDEX, SAG_OP_NSTORE, SAG_OP_LOAD_WORD, SAG_OP_STORE_WORD,
      SAG_OP_LOAD_BYTE, SAG_OP_STORE_BYTE, SAG_OP_LOAD_DOUBLE, SAG_OP_STORE_DOUBLE,
      SAG_OP_ADD_MEM, SAG_OP_CODE_WRITE
   } sagen_op_e;

   typedef enum logic [2:0] {
      SAG_STK_NONE, SAG_STK_PUSH, SAG_STK_POP, SAG_STK_CALL, SAG_STK_EXIT
   } sagen_stk_e;

   typedef struct packed {
      sagen_op_e   op;
      logic [15:0] instr;
      logic [15:0] direct_addr;
      logic        indirect;
      logic [15:0] index;
   } sagen_req_s;

   typedef struct packed {
      logic        valid;
      logic        code_seg;
      logic        write;
      logic [15:0] addr;
   } sagen_mem_s;
endpackage : sagen_pkg

/* verif/sagen_core_sva.sv */
// Checker for the segment address generator
`timescale 1ns/1ps
`default_nettype none
module sagen_core_sva
   import sagen_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // Inputs
   input wire logic        clk_en,
   input wire sagen_req_s  req,
   input wire logic        req_valid,
   input wire logic        instr_start,
   input wire sagen_stk_e  stk_op,
   input wire logic [15:0] stk_amount,
   input wire logic [15:0] call_local,
   // Outputs
   input wire sagen_mem_s  mem_req,
   input wire logic [15:0] pc,
   input wire logic [15:0] local_base,
   input wire logic [15:0] stack_ptr,
   input wire logic        addr_trap,
   input wire logic        busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic        take;
   logic [15:0] tgt;
   logic [15:0] dat;
   assign take = clk_en && req_valid && !busy;
   assign tgt  = pc + {{8{req.instr[7]}}, req.instr[7:0]} + req.index;
   assign dat  = req.direct_addr + req.index;
   a_code_direct_addr: assert property (take && req.op == SAG_OP_CODE_WORD && !req.instr[15]
      |=> mem_req.valid && mem_req.code_seg && mem_req.addr == $past(tgt)) else $error("code address wrong");
   a_data_word_addr: assert property (take && req.op == SAG_OP_LOAD_WORD && !req.indirect
      |=> mem_req.valid && !mem_req.code_seg && mem_req.addr == $past(dat)) else $error("data address wrong");
   a_mem_req_pulse: assert property (mem_req.valid && clk_en |=> !mem_req.valid) else $error("request too long");
   a_pc_step: assert property (instr_start && clk_en && !busy |=> pc == $past(pc) + 16'h0001)
      else $error("counter step wrong");
   a_code_write_trap: assert property (take && req.op == SAG_OP_CODE_WRITE |-> ##[1:3] addr_trap)
      else $error("no trap");
   a_no_code_write: assert property (!(mem_req.valid && mem_req.code_seg && mem_req.write))
      else $error("code written");
   a_call_local: assert property (clk_en && stk_op == SAG_STK_CALL |=> local_base == $past(call_local))
      else $error("local base wrong");
   a_push_stack: assert property (clk_en && stk_op == SAG_STK_PUSH
      |=> stack_ptr == $past(stack_ptr) + $past(stk_amount)) else $error("stack top wrong");
endmodule : sagen_core_sva
bind sagen_core sagen_core_sva sagen_core_sva_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .req(req),
   .req_valid(req_valid), .instr_start(instr_start), .stk_op(stk_op), .stk_amount(stk_amount),
   .call_local(call_local), .mem_req(mem_req), .pc(pc), .local_base(local_base), .stack_ptr(stack_ptr),
   .addr_trap(addr_trap), .busy(busy));
`default_nettype wire

/* verif/sagen_mem_model.sv */
// Memory model answering the address generator
`timescale 1ns/1ps
`default_nettype none
module sagen_mem_model
   import sagen_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Requests and answers
   input  wire sagen_mem_s mem_req,
   input  wire logic       slow,
   output logic [15:0]     mem_rdata,
   output logic            mem_rvalid
);
   logic [15:0] addr_q;
   logic [2:0]  wait_q;
   function automatic logic [15:0] word_at(input logic [15:0] a);
      return {a[6:0], a[15:7]} ^ 16'h6C31;
   endfunction : word_at
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_q     <= 3'h0;
         addr_q     <= 16'h0000;
         mem_rvalid <= 1'b0;
         mem_rdata  <= 16'h5A5A;
      end else begin
         mem_rvalid <= wait_q == 3'h1;
         mem_rdata  <= wait_q == 3'h1 ? word_at(addr_q) : ~mem_rdata;
         if (mem_req.valid && !mem_req.write) begin
            addr_q <= mem_req.addr;
            wait_q <= slow ? 3'h4 : 3'h1;
         end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
         end
      end
   end
endmodule : sagen_mem_model
`default_nettype wire

/* verif/segment_address_generator_bench.sv */
// Self-checking bench for the segment address generator
`timescale 1ns/1ps
`default_nettype none
module segment_address_generator_bench
   import sagen_pkg::*;
;
   logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0, instr_start = 1'b0, slow = 1'b0;
   logic        mem_rvalid, stack_top_load, byte_right, addr_trap, busy, all_same = 1'b0;
   logic [15:0] stk_amount = 16'h0000, call_local = 16'h0000, exit_local = 16'h0000;
   logic [15:0] mem_rdata, stack_top_data, pc, local_base, stack_ptr, exp_pc, la, lb, same_addr;
   logic [15:0] exp_addr[$], exp_data[$];
   logic [31:0] rnd = 32'h0001754B;
   sagen_req_s  req = '0;
   sagen_stk_e  stk_op = SAG_STK_NONE;
   sagen_mem_s  mem_req;
   int          num_errors = 0, comparisons = 0, cycles = 0, traps = 0;
   always #20 clk = ~clk;
   sagen_core sagen_core_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .req(req), .req_valid(req_valid),
      .instr_start(instr_start), .stk_op(stk_op), .stk_amount(stk_amount), .call_local(call_local),
      .exit_local(exit_local), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_req(mem_req),
      .stack_top_data(stack_top_data), .stack_top_load(stack_top_load), .pc(pc), .local_base(local_base),
      .stack_ptr(stack_ptr), .byte_right(byte_right), .addr_trap(addr_trap), .busy(busy));
   sagen_mem_model sagen_mem_model_i (.clk(clk), .reset_n(reset_n), .mem_req(mem_req), .slow(slow),
      .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
   function automatic logic [15:0] rand16();
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      return rnd[15:0];
   endfunction : rand16
   task automatic final_report();
      if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Result watcher
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
      if (addr_trap === 1'b1) traps++;
      if (mem_req.valid === 1'b1)
         check("addr", all_same ? same_addr : exp_addr.size() ? exp_addr.pop_front() : 'x, mem_req.addr);
      if (stack_top_load === 1'b1 && !all_same)
         check("data", exp_data.size() ? exp_data.pop_front() : 'x, stack_top_data);
   end
   task automatic issue(input sagen_op_e op, input logic [15:0] ins, da, idx, input logic ind);
      int n;
      @(posedge clk) #1;
      req = '{op, ins, da, ind, idx};
      req_valid = 1'b1;
      @(posedge clk) #1;
      req_valid = 1'b0;
      for (n = 0; busy !== 1'b0 && n < 60; n++) @(posedge clk) #1;
      if (n == 60) check("busy", 16'h0000, 16'h0001);
   endtask : issue
   task automatic code_op(input sagen_op_e op, input logic [7:0] d, input logic [15:0] idx, input logic ind);
      la = exp_pc + {{8{d[7]}}, d};
      if (ind) exp_addr.push_back(la);
      if (ind) la = la + sagen_mem_model_i.word_at(la);
      if (op == SAG_OP_CODE_BYTE) la = {exp_pc[15], 15'(la + {1'b0, idx[15:1]})};
      else la = la + idx;
      exp_addr.push_back(la);
      if (op != SAG_OP_BRANCH) exp_data.push_back(sagen_mem_model_i.word_at(la));
      else exp_pc = la + 16'h0001;
      issue(op, {ind, 7'h00, d}, 16'h0000, idx, 1'b0);
      check("pc", exp_pc, pc);
      if (op == SAG_OP_CODE_BYTE) check("byte", {15'h0000, idx[0]}, {15'h0000, byte_right});
   endtask : code_op
   task automatic stk(input sagen_stk_e op, input logic [15:0] amt, loc);
      @(posedge clk) #1;
      stk_op = op;
      stk_amount = amt;
      call_local = loc;
      exit_local = loc;
      @(posedge clk) #1 stk_op = SAG_STK_NONE;
      @(posedge clk) #1;
   endtask : stk
   initial begin
      repeat (4) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge clk);
      exp_pc = 16'h0000;
      check("pc", exp_pc, pc);
      check("local", 16'h0000, local_base);
      check("stack", 16'h0000, stack_ptr);
      repeat (3) begin
         @(posedge clk) #1 instr_start = 1'b1;
         @(posedge clk) #1 instr_start = 1'b0;
         exp_pc++;
      end
      check("pc", exp_pc, pc);
      @(posedge clk) #1 clk_en = 1'b0;
      instr_start = 1'b1;
      repeat (3) @(posedge clk);
      #1 instr_start = 1'b0;
      clk_en = 1'b1;
      check("pc", exp_pc, pc);
      for (int i = 0; i < 8; i++) begin
         slow = i[0];
         lb = i[1:0] == 0 ? 16'h007F : i[1:0] == 1 ? 16'h0080 : rand16();
         code_op(SAG_OP_CODE_WORD, lb[7:0], rand16(), i[2]);
      end
      for (int i = 0; i < 2; i++) code_op(SAG_OP_BRANCH, lb[7:0], 16'h0000, i[0]);
      for (int i = 0; i < 2; i++) code_op(SAG_OP_CODE_BYTE, 8'(rand16()), i[0] ? 16'hFFFF : rand16(), i[0]);
      for (int i = 0; i < 4; i++) begin
         slow = i[0];
         la = rand16();
         lb = rand16();
         exp_addr.push_back(i[0] ? la : la + lb);
         if (i[0]) exp_addr.push_back(sagen_mem_model_i.word_at(la) + lb);
         if (i < 3) exp_data.push_back(sagen_mem_model_i.word_at(exp_addr[exp_addr.size() - 1]));
         issue(i < 3 ? SAG_OP_LOAD_WORD : SAG_OP_STORE_WORD, 16'h0000, la, lb, i[0]);
      end
      la = rand16();
      lb = rand16();
      same_addr = sagen_mem_model_i.word_at(la);
      exp_addr.push_back(la);
      exp_addr.push_back({1'b0, same_addr[15:1]} + lb);
      exp_data.push_back(sagen_mem_model_i.word_at({1'b0, same_addr[15:1]} + lb));
      issue(SAG_OP_LOAD_BYTE, 16'h0000, la, lb, 1'b1);
      check("byte", {15'h0000, same_addr[0]}, {15'h0000, byte_right});
      all_same = 1'b1;
      for (int k = SAG_OP_LOAD_INDEX; k <= SAG_OP_ADD_MEM; k++) begin
         same_addr = rand16();
         issue(sagen_op_e'(k), 16'h0000, same_addr, 16'h0000, 1'b0);
      end
      @(posedge clk) #1 all_same = 1'b0;
      traps = 0;
      issue(SAG_OP_CODE_WRITE, 16'h0000, 16'h0000, 16'h0000, 1'b0);
      repeat (3) @(posedge clk);
      check("trap", 16'h0001, 16'(traps));
      la = rand16();
      stk(SAG_STK_CALL, 16'h0004, la);
      check("local", la, local_base);
      lb = stack_ptr;
      stk(SAG_STK_PUSH, 16'h0003, la);
      check("stack", lb + 16'h0003, stack_ptr);
      stk(SAG_STK_POP, 16'h0002, la);
      check("stack", lb + 16'h0001, stack_ptr);
      stk(SAG_STK_EXIT, 16'h0004, 16'h0000);
      check("local", 16'h0000, local_base);
      final_report();
   end
endmodule : segment_address_generator_bench
`default_nettype wire
